// file: common/prox_cfg_pkg.sv
/*
  Package for the proximity emitter and gain configuration bank: register
  offsets, field positions, reset values and field limits.
  Assumes an 8-bit register port with byte addresses from the serial
  register interface of the device.
*/
`default_nettype none
package prox_cfg_pkg;
  localparam logic [7:0] ADDR_SCALER_SLAVE2 = 8'hAB;
  localparam logic [7:0] ADDR_SLAVE1_MASTER = 8'hAC;
  localparam logic [7:0] ADDR_ENGINE_GAIN   = 8'hAD;
  localparam logic [7:0] ADDR_PULSE_COUNT   = 8'hAE;

  localparam int RELEASE_LSB = 6;
  localparam int DETECT_LSB  = 4;
  localparam int SLAVE2_LSB  = 0;
  localparam int SLAVE1_LSB  = 4;
  localparam int MASTER_LSB  = 0;
  localparam int GAIN1_LSB   = 2;
  localparam int GAIN0_LSB   = 0;

  localparam logic [1:0] RST_SCALER = 2'h0;
  localparam logic [3:0] RST_SINK   = 4'h0;
  localparam logic [1:0] RST_GAIN   = 2'h2;
  localparam logic [7:0] RST_PULSE  = 8'h0F;

  localparam logic [3:0] SINK_MAX   = 4'h7;
endpackage : prox_cfg_pkg
`default_nettype wire

// file: rtl/sink_field_clamp.sv
/*
  Clamp for one 4-bit sink current setting: limits it to the largest
  legal code.
  Assumes a write value straight from the register port.
*/
`default_nettype none
module sink_field_clamp (
  input  wire logic [3:0] raw_in,
  output logic      [3:0] clamped_out
);
  import prox_cfg_pkg::*;

  // over-range codes would overdrive the emitter, so cap them
  always_comb begin
    clamped_out = (raw_in > SINK_MAX) ? SINK_MAX : raw_in;
  end
endmodule // sink_field_clamp
`default_nettype wire

// file: rtl/prox_emitter_gain_config_regs.sv
/*
  Configuration bank for the proximity emitter driver and gain stages:
  sink scalers, sink currents, engine gains and pulse count, with decoded
  values for the emitter driver and a pulse limiter per sample.
  Assumes the serial register interface delivers one-cycle write strobes
  and a read address on sys_clk_in; the emitter reports pulse requests.
*/
`default_nettype none
module prox_emitter_gain_config_regs (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       wr_en_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       sample_start_in,
  input  wire logic       pulse_req_in,
  output logic      [7:0] rd_data_out,
  output logic      [2:0] release_scale_half_out,
  output logic      [2:0] detect_scale_half_out,
  output logic      [3:0] slave2_ma_out,
  output logic      [3:0] slave1_ma_out,
  output logic      [3:0] master_ma_out,
  output logic      [3:0] engine1_gain_x_out,
  output logic      [3:0] engine0_gain_x_out,
  output logic      [8:0] pulse_total_out,
  output logic            pulse_fire_out
);
  import prox_cfg_pkg::*;

  logic [1:0] release_sink_scaler_r, release_sink_scaler_nxt;
  logic [1:0] detect_sink_scaler_r, detect_sink_scaler_nxt;
  logic [3:0] second_slave_sink_current_r, second_slave_sink_current_nxt;
  logic [3:0] first_slave_sink_current_r, first_slave_sink_current_nxt;
  logic [3:0] master_sink_current_r, master_sink_current_nxt;
  logic [1:0] engine_one_gain_r, engine_one_gain_nxt;
  logic [1:0] engine_zero_gain_r, engine_zero_gain_nxt;
  logic [7:0] pulse_count_minus_one_r, pulse_count_minus_one_nxt;
  logic [7:0] rd_data_nxt;
  logic [3:0] slave2_clamped;
  logic [3:0] slave1_clamped;
  logic [3:0] master_clamped;
  logic [8:0] pulses_done_r, pulses_done_nxt;
  logic       pulse_fire_nxt;

  // scaler in half steps: code 0..3 gives 1..4 halves (0.5x to 2x)
  function automatic logic [2:0] scale_halves(input logic [1:0] code);
    scale_halves = {1'b0, code} + 3'h1;
  endfunction

  // gain code 0..3 gives 1x, 2x, 4x, 8x
  function automatic logic [3:0] gain_mult(input logic [1:0] code);
    gain_mult = 4'h1 << code;
  endfunction

  sink_field_clamp u_clamp_slave2 (
    .raw_in      (wr_data_in[SLAVE2_LSB +: 4]),
    .clamped_out (slave2_clamped)
  );
  sink_field_clamp u_clamp_slave1 (
    .raw_in      (wr_data_in[SLAVE1_LSB +: 4]),
    .clamped_out (slave1_clamped)
  );
  sink_field_clamp u_clamp_master (
    .raw_in      (wr_data_in[MASTER_LSB +: 4]),
    .clamped_out (master_clamped)
  );

  // register writes; sink fields are clamped so the cap holds in hardware
  always_comb begin
    release_sink_scaler_nxt       = release_sink_scaler_r;
    detect_sink_scaler_nxt        = detect_sink_scaler_r;
    second_slave_sink_current_nxt = second_slave_sink_current_r;
    first_slave_sink_current_nxt  = first_slave_sink_current_r;
    master_sink_current_nxt       = master_sink_current_r;
    engine_one_gain_nxt           = engine_one_gain_r;
    engine_zero_gain_nxt          = engine_zero_gain_r;
    pulse_count_minus_one_nxt     = pulse_count_minus_one_r;
    if (wr_en_in) begin
      case (addr_in)
        ADDR_SCALER_SLAVE2: begin
          release_sink_scaler_nxt = wr_data_in[RELEASE_LSB +: 2];
          detect_sink_scaler_nxt  = wr_data_in[DETECT_LSB +: 2];
          second_slave_sink_current_nxt = slave2_clamped;
        end
        ADDR_SLAVE1_MASTER: begin
          first_slave_sink_current_nxt = slave1_clamped;
          master_sink_current_nxt      = master_clamped;
        end
        ADDR_ENGINE_GAIN: begin
          // bits 7:4 dropped on purpose
          engine_one_gain_nxt  = wr_data_in[GAIN1_LSB +: 2];
          engine_zero_gain_nxt = wr_data_in[GAIN0_LSB +: 2];
        end
        ADDR_PULSE_COUNT: begin
          pulse_count_minus_one_nxt = wr_data_in;
        end
        default: begin
          pulse_count_minus_one_nxt = pulse_count_minus_one_r;
        end
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (addr_in)
      ADDR_SCALER_SLAVE2: rd_data_nxt = {release_sink_scaler_r,
          detect_sink_scaler_r, second_slave_sink_current_r};
      ADDR_SLAVE1_MASTER: rd_data_nxt = {first_slave_sink_current_r,
          master_sink_current_r};
      ADDR_ENGINE_GAIN: rd_data_nxt = {4'h0, engine_one_gain_r,
          engine_zero_gain_r};
      ADDR_PULSE_COUNT: rd_data_nxt = pulse_count_minus_one_r;
      default: rd_data_nxt = 8'h00;
    endcase
  end

  // pulse limiter: a request fires only while the sample budget remains;
  // a new sample start resets the count and may fire in the same cycle
  always_comb begin
    logic [8:0] base;
    base = sample_start_in ? 9'h000 : pulses_done_r;
    pulse_fire_nxt  = 1'b0;
    pulses_done_nxt = base;
    if (pulse_req_in && (base < ({1'b0, pulse_count_minus_one_r} +
        9'h001))) begin
      pulse_fire_nxt  = 1'b1;
      pulses_done_nxt = base + 9'h001;
    end
  end

  // all state and registered outputs
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      release_sink_scaler_r       <= RST_SCALER;
      detect_sink_scaler_r        <= RST_SCALER;
      second_slave_sink_current_r <= RST_SINK;
      first_slave_sink_current_r  <= RST_SINK;
      master_sink_current_r       <= RST_SINK;
      engine_one_gain_r           <= RST_GAIN;
      engine_zero_gain_r          <= RST_GAIN;
      pulse_count_minus_one_r     <= RST_PULSE;
      pulses_done_r               <= 9'h000;
      rd_data_out                 <= 8'h00;
      release_scale_half_out      <= 3'h1;
      detect_scale_half_out       <= 3'h1;
      slave2_ma_out               <= 4'h0;
      slave1_ma_out               <= 4'h0;
      master_ma_out               <= 4'h1;
      engine1_gain_x_out          <= 4'h4;
      engine0_gain_x_out          <= 4'h4;
      pulse_total_out             <= 9'h010;
      pulse_fire_out              <= 1'b0;
    end else begin
      release_sink_scaler_r       <= release_sink_scaler_nxt;
      detect_sink_scaler_r        <= detect_sink_scaler_nxt;
      second_slave_sink_current_r <= second_slave_sink_current_nxt;
      first_slave_sink_current_r  <= first_slave_sink_current_nxt;
      master_sink_current_r       <= master_sink_current_nxt;
      engine_one_gain_r           <= engine_one_gain_nxt;
      engine_zero_gain_r          <= engine_zero_gain_nxt;
      pulse_count_minus_one_r     <= pulse_count_minus_one_nxt;
      pulses_done_r               <= pulses_done_nxt;
      rd_data_out                 <= rd_data_nxt;
      release_scale_half_out <= scale_halves(release_sink_scaler_nxt);
      detect_scale_half_out  <= scale_halves(detect_sink_scaler_nxt);
      slave2_ma_out          <= second_slave_sink_current_nxt;
      slave1_ma_out          <= first_slave_sink_current_nxt;
      master_ma_out          <= master_sink_current_nxt + 4'h1;
      engine1_gain_x_out     <= gain_mult(engine_one_gain_nxt);
      engine0_gain_x_out     <= gain_mult(engine_zero_gain_nxt);
      pulse_total_out  <= {1'b0, pulse_count_minus_one_nxt} + 9'h001;
      pulse_fire_out   <= pulse_fire_nxt;
    end
  end

  // decoded outputs take the next field values, so they change on the same edge as the stored fields
  sink_cap_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    slave1_ma_out <= 4'h7 && slave2_ma_out <= 4'h7 && master_ma_out <= 4'h8)
    else $error("sink current above cap");
  master_offset_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    master_ma_out == master_sink_current_r + 4'h1)
    else $error("master current offset wrong");
  // a count lowered mid-sample may leave the tally above the budget, so
  // only a grant after the budget is spent counts as a breach
  pulse_limit_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    pulse_req_in && !sample_start_in &&
    pulses_done_r >= {1'b0, pulse_count_minus_one_r} + 9'h001 |=>
    !pulse_fire_out)
    else $error("pulse count exceeded");
  pulse_write_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == ADDR_PULSE_COUNT |=>
    pulse_total_out == {1'b0, $past(wr_data_in)} + 9'h001)
    else $error("pulse total not value plus one");
  gain_rsvd_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    $past(addr_in) == ADDR_ENGINE_GAIN |-> rd_data_out[7:4] == 4'h0)
    else $error("gain reserved bits nonzero");
  release_scale_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == ADDR_SCALER_SLAVE2 |=>
    release_scale_half_out == {1'b0, $past(wr_data_in[7:6])} + 3'h1)
    else $error("release scaler wrong");
  detect_scale_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == ADDR_SCALER_SLAVE2 |=>
    detect_scale_half_out == {1'b0, $past(wr_data_in[5:4])} + 3'h1)
    else $error("detect scaler wrong");
  engine1_gain_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == ADDR_ENGINE_GAIN |=>
    engine1_gain_x_out == (4'h1 << $past(wr_data_in[3:2])))
    else $error("engine one gain wrong");
  engine0_gain_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == ADDR_ENGINE_GAIN |=>
    engine0_gain_x_out == (4'h1 << $past(wr_data_in[1:0])))
    else $error("engine zero gain wrong");
  slave_fields_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == ADDR_SLAVE1_MASTER &&
    wr_data_in[7:4] <= 4'h7 |=> slave1_ma_out == $past(wr_data_in[7:4]))
    else $error("slave one current wrong");
  slave2_field_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == ADDR_SCALER_SLAVE2 &&
    wr_data_in[3:0] <= 4'h7 |=> slave2_ma_out == $past(wr_data_in[3:0]))
    else $error("slave two current wrong");
endmodule // prox_emitter_gain_config_regs
`default_nettype wire

// file: tb/host_reg_model.sv
/*
  Host side model: byte register writes and reads on the config bank.
  Assumes one clock; the bench calls its tasks by hierarchical name.
*/
`default_nettype none
module host_reg_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rd_data_in,
  output var  logic       wr_en_out,
  output var  logic [7:0] addr_out,
  output var  logic [7:0] wr_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    wr_en_out = 1'b0;
    addr_out = 8'h00;
    wr_data_out = 8'h00;
  end
  // one-cycle strobe; data inverted after release so stale bytes never match
  // a real host keeps sink fields at seven or less; tests overshoot
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_en_out   <= 1'b1;
    addr_out    <= a;
    wr_data_out <= d;
    @(posedge clk_in);
    wr_en_out   <= 1'b0;
    wr_data_out <= ~d;
  endtask
  // read data is registered, so it is taken one edge after the address
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    @(posedge clk_in);
    #1 d = rd_data_in;
  endtask
endmodule // host_reg_model
`default_nettype wire

// file: tb/prox_emitter_gain_config_regs_tb_top.sv
/*
  Self-checking bench for the proximity config bank.
  Assumes the host model drives the register port; bench drives pulses.
*/
`default_nettype none
module prox_emitter_gain_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import prox_cfg_pkg::*;
  logic sys_clk_in = 1'b0, rst_n_in = 1'b0, wr_en, start = 1'b0, req = 1'b0;
  logic [7:0] addr, wr_data, rd_data, d;
  logic [2:0] rel, det;
  logic [3:0] s2, s1, m, g1, g0;
  logic [8:0] total;
  logic       fire;
  int         err_count = 0, samples_checked = 0, n;
  always #25 sys_clk_in = ~sys_clk_in;
  host_reg_model host_reg_model_inst (.clk_in(sys_clk_in),
    .rd_data_in(rd_data), .wr_en_out(wr_en), .addr_out(addr),
    .wr_data_out(wr_data));
  prox_emitter_gain_config_regs prox_emitter_gain_config_regs_inst (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en),
    .addr_in(addr), .wr_data_in(wr_data), .sample_start_in(start),
    .pulse_req_in(req), .rd_data_out(rd_data),
    .release_scale_half_out(rel), .detect_scale_half_out(det),
    .slave2_ma_out(s2), .slave1_ma_out(s1), .master_ma_out(m),
    .engine1_gain_x_out(g1), .engine0_gain_x_out(g0),
    .pulse_total_out(total), .pulse_fire_out(fire));
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host_reg_model_inst.write_reg(a, v);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host_reg_model_inst.read_reg(a, d);
    check(9'(d), 9'(exp));
  endtask
  // reset values of every register and decoded output, plus unmapped read
  task automatic test_reset;
    rd(8'hAB, 8'h00);
    rd(8'hAC, 8'h00);
    rd(8'hAD, 8'h0A);
    rd(8'hAE, 8'h0F);
    rd(8'hAF, 8'h00);
    check(9'(rel), 9'h001);
    check(9'(det), 9'h001);
    check(9'(s2), 9'h000);
    check(9'(s1), 9'h000);
    check(9'(m), 9'h001);
    check(9'(g1), 9'h004);
    check(9'(g0), 9'h004);
    check(total, 9'h010);
  endtask
  // every scaler code in both fields, slave two stepped through 4..7
  task automatic test_scalers;
    for (int c = 0; c < 4; c++) begin
      wr(8'hAB, {2'(c), 2'(3 - c), 4'(c + 4)});
      check(9'(rel), 9'(c + 1));
      check(9'(det), 9'(4 - c));
      check(9'(s2), 9'(c + 4));
    end
    wr(8'hAB, 8'h0F);
    check(9'(s2), 9'h007);
    rd(8'hAB, 8'h07);
  endtask
  // over-range sink codes must be stored as seven; slave one drives seven, master drives eight
  task automatic test_sinks;
    wr(8'hAC, 8'h9F);
    check(9'(s1), 9'h007);
    check(9'(m), 9'h008);
    rd(8'hAC, 8'h77);
    wr(8'hAC, 8'h30);
    check(9'(s1), 9'h003);
    check(9'(m), 9'h001);
  endtask
  // all gain codes; reserved upper bits written as ones read back zero
  task automatic test_gains;
    for (int c = 0; c < 4; c++) begin
      wr(8'hAD, {4'hF, 2'(c), 2'(3 - c)});
      check(9'(g1), 9'(1 << c));
      check(9'(g0), 9'(1 << (3 - c)));
      rd(8'hAD, {4'h0, 2'(c), 2'(3 - c)});
    end
  endtask
  // budget of three pulses against a request held for eight cycles, twice,
  // so a new sample start must restore the budget
  task automatic test_pulses;
    wr(8'hAE, 8'h02);
    check(total, 9'h003);
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk_in);
      start <= 1'b1;
      req   <= 1'b1;
      @(posedge sys_clk_in);
      start <= 1'b0;
      n = 0;
      for (int i = 0; i < 8; i++) begin
        #1 if (fire === 1'b1) n++;
        @(posedge sys_clk_in);
      end
      check(9'(n), 9'h003);
    end
    req <= 1'b0;
    wr(8'hAE, 8'hFF);
    check(total, 9'h100);
    wr(8'hAF, 8'h55);
    rd(8'hAF, 8'h00);
    rd(8'hAE, 8'hFF);
  endtask
  // reset in mid-run must bring the gain and pulse count fields back to their reset values
  task automatic test_mid_reset;
    wr(8'hAD, 8'h05);
    @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd(8'hAD, 8'h0A);
    rd(8'hAE, 8'h0F);
    check(9'(g0), 9'h004);
    check(total, 9'h010);
  endtask
  // watchdog: the whole run needs under a hundred cycles
  initial begin
    #100000;
    err_count++;
    final_report();
  end
  // reset for three cycles, then the scenarios in turn
  initial begin
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    test_reset();
    test_scalers();
    test_sinks();
    test_gains();
    test_pulses();
    test_mid_reset();
    final_report();
  end
endmodule // prox_emitter_gain_config_regs_tb_top
`default_nettype wire
